/* hdl/fchk_pkg.sv */
// Behaviour
// - data line held low past timeout resets serial interface and releases data line
// - tach timebase is one quarter of the oscillator, nominally 8192 Hz
// - frequency strap sampled once at power-up sets initial pwm frequency
// - spin-up strap sampled once at power-up sets initial spin-up behaviour
// - both address selects re-sampled at start of every bus transaction
// - each address select decodes four states; two pins give 16 addresses
// - after reset run from internal oscillator and drive 32768 Hz clock out
// - crystal oscillator stays off until software enables it by register write
// - enabled crystal drives the clock output while crystal_ok_in is high; clock output always active
// - two duty straps sampled at power-up set initial duty of six outputs
package fchk_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned TIMEOUT_MIN_MS  = 25;
    localparam int unsigned TIMEOUT_MAX_MS  = 45;
    // 25 ms least, in whole cycles; exact at 10 MHz, per-ms count rounded down
    localparam int unsigned TIMEOUT_CYC     = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
    localparam int unsigned OSC_HZ          = 32_768;
    localparam int unsigned TACH_DIV        = 4;
    localparam int unsigned TACH_HZ         = OSC_HZ / TACH_DIV;
    // clock-out toggles twice per period; rounded down
    localparam int unsigned OSC_HALF_CYC    = CLK_HZ / (2 * OSC_HZ);
    localparam int unsigned APB_AW          = 8;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STRAP      = 8'h04;
    localparam logic [7:0]  ADDR_STAT       = 8'h08;
    localparam int unsigned CTRL_XTAL_EN    = 0;
    localparam logic [6:0]  BASE_ADDR       = 7'h20;
    localparam int unsigned STRAP_FREQ_BIT  = 0;
    localparam int unsigned STRAP_SPIN_BIT  = 1;
    localparam int unsigned STRAP_WD_BIT    = 2;
    localparam int unsigned STRAP_DUTY_LSB  = 3;
    localparam logic [4:0]  STRAP_RESET     = 5'h00;
    typedef enum logic [1:0] {SEL_GND, SEL_VCC, SEL_SDA, SEL_SCL} fchk_sel_e;
endpackage : fchk_pkg

/* hdl/fchk_sel_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// one address-select pin: resolves which net it is tied to
module fchk_sel_decode
    import fchk_pkg::*;
(
    input  wire logic       lvl_start_in,  // pin at start: data low, clock high
    input  wire logic       lvl_idle_in,   // pin one cycle earlier: data high
    input  wire logic       lvl_scl_lo_in, // pin while the clock line is low
    output var fchk_sel_e   sel_out        // decoded connection
);
    // low at start: ground, or the data line if it was high just before
    // high at start: supply, or the clock line if it follows the clock low
    always_comb begin
        if (!lvl_start_in) begin
            sel_out = lvl_idle_in ? SEL_SDA : SEL_GND;
        end else begin
            sel_out = lvl_scl_lo_in ? SEL_VCC : SEL_SCL;
        end
    end
endmodule // fchk_sel_decode
`default_nettype wire

/* hdl/fchk_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fchk_top
    import fchk_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC   // data-low timeout
) (
    input  wire logic                   clk_in,            // 10 MHz clock
    input  wire logic                   rst_in,            // sync reset, high
    input  wire logic                   psel_in,           // apb select
    input  wire logic                   penable_in,        // apb enable
    input  wire logic                   pwrite_in,         // apb write
    input  wire logic [APB_AW-1:0]      paddr_in,          // apb address
    input  wire logic [31:0]            pwdata_in,         // apb write data
    output logic      [31:0]            prdata_out,        // apb read data
    output logic                        pready_out,        // apb ready
    output logic                        pslverr_out,       // apb error
    input  wire logic                   pwm_freq_strap_in, // frequency strap
    input  wire logic                   spin_strap_in,     // spin-up strap
    input  wire logic                   bus_watchdog_strap_in, // watchdog strap
    input  wire logic                   duty_strap_bit0_in, // duty strap lsb
    input  wire logic                   duty_strap_bit1_in, // duty strap msb
    input  wire logic                   addr_select_a_in,  // address select a
    input  wire logic                   addr_select_b_in,  // address select b
    input  wire logic                   scl_in,            // bus clock level
    input  wire logic                   sda_in,            // bus data level
    input  wire logic                   bus_start_in,      // start seen, pulse
    input  wire logic                   crystal_in,        // crystal osc level
    input  wire logic                   crystal_ok_in,     // crystal fitted/run
    output logic                        crystal_en_out,    // crystal enable
    output logic                        timebase_clock_out, // 32768 Hz clock
    output logic                        tach_tick_out,     // 8192 Hz enable
    output logic                        sda_oe_n_out,      // low: pull data low
    output logic                        bus_reset_out,     // serial if reset pulse
    output logic [6:0]                  dev_addr_out,      // decoded address
    output logic                        pwm_freq_init_out, // initial freq sel
    output logic                        spin_init_out,     // initial spin sel
    output logic                        watchdog_init_out, // initial wd sel
    output logic [1:0]                  duty_init_out,     // initial duty sel
    input  wire logic                   sda_drive_low_in   // serial core drives low
);
    import fchk_pkg::*;

    logic [4:0]  strap_q;
    logic        captured_q;
    logic        xtal_en_q;
    logic [31:0] to_cnt_q;
    logic [15:0] half_cnt_q;
    logic        clk_int_q;
    logic        xtal_d1_q;
    logic        xtal_d2_q;
    logic [1:0]  quarter_q;
    logic        tb_edge;
    fchk_sel_e   sel_a;
    fchk_sel_e   sel_b;
    logic [1:0]  pin_prev_q;
    logic [1:0]  lvl_start_q;
    logic [1:0]  lvl_idle_q;
    logic        addr_wait_q;
    logic [9:0]  still_cnt_q;

    // capture once after reset release; only a new reset rearms it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strap_q    <= STRAP_RESET;
            captured_q <= 1'b0;
        end else if (!captured_q) begin
            strap_q[STRAP_FREQ_BIT] <= pwm_freq_strap_in;
            strap_q[STRAP_SPIN_BIT] <= spin_strap_in;
            strap_q[STRAP_WD_BIT]   <= bus_watchdog_strap_in;
            strap_q[STRAP_DUTY_LSB+:2] <= {duty_strap_bit1_in, duty_strap_bit0_in};
            captured_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwm_freq_init_out <= 1'b0;
            spin_init_out     <= 1'b0;
            watchdog_init_out <= 1'b0;
            duty_init_out     <= 2'h0;
        end else begin
            pwm_freq_init_out <= strap_q[STRAP_FREQ_BIT];
            spin_init_out     <= strap_q[STRAP_SPIN_BIT];
            watchdog_init_out <= strap_q[STRAP_WD_BIT];
            duty_init_out     <= strap_q[STRAP_DUTY_LSB+:2];
        end
    end

    fchk_sel_decode u_dec_a (
        .lvl_start_in  (lvl_start_q[0]),
        .lvl_idle_in   (lvl_idle_q[0]),
        .lvl_scl_lo_in (addr_select_a_in),
        .sel_out       (sel_a)
    );
    fchk_sel_decode u_dec_b (
        .lvl_start_in  (lvl_start_q[1]),
        .lvl_idle_in   (lvl_idle_q[1]),
        .lvl_scl_lo_in (addr_select_b_in),
        .sel_out       (sel_b)
    );

    // a start alone cannot tell ground from a data tie or supply from a clock tie:
    // the level one cycle earlier (data still high) and at the first clock low decide
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_prev_q  <= 2'h0;
            lvl_start_q <= 2'h0;
            lvl_idle_q  <= 2'h0;
            addr_wait_q <= 1'b0;
        end else begin
            pin_prev_q <= {addr_select_b_in, addr_select_a_in};
            if (bus_start_in) begin
                lvl_start_q <= {addr_select_b_in, addr_select_a_in};
                lvl_idle_q  <= pin_prev_q;
                addr_wait_q <= 1'b1;
            end else if (addr_wait_q && !scl_in) begin
                addr_wait_q <= 1'b0;
            end
        end
    end

    // limitation: the start pulse must come on the first edge the data line is seen low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dev_addr_out <= BASE_ADDR;
        end else if (addr_wait_q && !scl_in && !bus_start_in) begin
            dev_addr_out <= {BASE_ADDR[6:4], sel_b, sel_a};
        end
    end

    // data-low timer; counts only while the line is low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            to_cnt_q      <= 32'h0;
            bus_reset_out <= 1'b0;
        end else begin
            bus_reset_out <= 1'b0;
            if (sda_in) begin
                to_cnt_q <= 32'h0;
            end else if (to_cnt_q == TIMEOUT_CYCLES - 1) begin
                to_cnt_q      <= 32'h0;
                bus_reset_out <= 1'b1;
            end else begin
                to_cnt_q <= to_cnt_q + 32'h1;
            end
        end
    end

    // the timeout pulse overrides the serial core so the line is released at once
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sda_oe_n_out <= 1'b1;
        end else if (!sda_in && to_cnt_q == TIMEOUT_CYCLES - 1) begin
            sda_oe_n_out <= 1'b1;
        end else begin
            sda_oe_n_out <= !sda_drive_low_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            xtal_en_q <= 1'b0;
        end else if (psel_in && penable_in && pwrite_in && paddr_in == ADDR_CTRL) begin
            xtal_en_q <= pwdata_in[CTRL_XTAL_EN];
        end
    end
    assign crystal_en_out = xtal_en_q;

    // internal oscillator model: divider of the system clock
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            half_cnt_q <= 16'h0;
            clk_int_q  <= 1'b0;
        end else if (half_cnt_q == 16'(OSC_HALF_CYC - 1)) begin
            half_cnt_q <= 16'h0;
            clk_int_q  <= !clk_int_q;
        end else begin
            half_cnt_q <= half_cnt_q + 16'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            xtal_d1_q <= 1'b0;
            xtal_d2_q <= 1'b0;
        end else begin
            xtal_d1_q <= crystal_in;
            xtal_d2_q <= xtal_d1_q;
        end
    end

    // fall back to internal osc until the crystal runs so the output never stops
    logic use_xtal;
    logic src_lvl;
    assign use_xtal = xtal_en_q && crystal_ok_in;
    assign src_lvl  = use_xtal ? xtal_d2_q : clk_int_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            timebase_clock_out <= 1'b0;
        end else begin
            timebase_clock_out <= src_lvl;
        end
    end
    assign tb_edge = src_lvl && !timebase_clock_out;

    // cycles since the clock output last moved, saturating; only watched by an assertion
    // so a stuck source during a switch-over is caught
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            still_cnt_q <= 10'h000;
        end else if (src_lvl != timebase_clock_out) begin
            still_cnt_q <= 10'h000;
        end else if (still_cnt_q != 10'h3FF) begin
            still_cnt_q <= still_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            quarter_q     <= 2'h0;
            tach_tick_out <= 1'b0;
        end else begin
            tach_tick_out <= 1'b0;
            if (tb_edge) begin
                quarter_q <= quarter_q + 2'h1;
                tach_tick_out <= (quarter_q == 2'(TACH_DIV - 1));
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out  <= 32'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            if (psel_in && !penable_in) begin
                prdata_out <= 32'h0;
                case (paddr_in)
                    ADDR_CTRL:  prdata_out <= {31'h0, xtal_en_q};
                    ADDR_STRAP: prdata_out <= {27'h0, strap_q};
                    ADDR_STAT:  prdata_out <= {24'h0, use_xtal, dev_addr_out};
                    default:    pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    a_strap_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        captured_q && $past(captured_q) |-> $stable(strap_q))
        else $error("strap value changed after capture");
    a_strap_freq: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(captured_q) |-> strap_q[STRAP_FREQ_BIT] == $past(pwm_freq_strap_in))
        else $error("frequency strap not captured");
    a_strap_spin: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(captured_q) |-> strap_q[STRAP_SPIN_BIT] == $past(spin_strap_in))
        else $error("spin strap not captured");
    a_strap_wd: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(captured_q) |-> strap_q[STRAP_WD_BIT] == $past(bus_watchdog_strap_in))
        else $error("watchdog strap not captured");
    a_strap_duty: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(captured_q) |-> ##1 duty_init_out == $past(strap_q[STRAP_DUTY_LSB+:2]))
        else $error("duty strap not forwarded");
    sequence s_low_full;
        !sda_in && to_cnt_q == TIMEOUT_CYCLES - 1;
    endsequence
    a_timeout_release: assert property (@(posedge clk_in) disable iff (rst_in)
        s_low_full |=> bus_reset_out && sda_oe_n_out)
        else $error("timeout did not release data line");
    sequence s_addr_commit;
        addr_wait_q && !scl_in && !bus_start_in;
    endsequence
    a_addr_start: assert property (@(posedge clk_in) disable iff (rst_in)
        bus_start_in |=> addr_wait_q
            && lvl_start_q == $past({addr_select_b_in, addr_select_a_in}))
        else $error("select levels not taken at start");
    a_addr_sample: assert property (@(posedge clk_in) disable iff (rst_in)
        s_addr_commit |=> dev_addr_out[3:0] == $past({sel_b, sel_a}))
        else $error("address not sampled at start");
    a_xtal_off: assert property (@(posedge clk_in) disable iff (rst_in)
        xtal_en_q && !$past(xtal_en_q) |-> $past(psel_in && penable_in && pwrite_in
            && paddr_in == ADDR_CTRL))
        else $error("crystal enabled without write");
    a_wr_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && penable_in && pwrite_in && paddr_in != ADDR_CTRL |=> $stable(xtal_en_q))
        else $error("crystal enable changed by foreign write");
    a_timebase_clock_out_alive: assert property (@(posedge clk_in) disable iff (rst_in)
        still_cnt_q < 2 * OSC_HALF_CYC)
        else $error("clock output stopped");
    // zero-wait slave: every setup is answered at the first access edge
    a_apb_answer: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    a_apb_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && !penable_in && paddr_in != ADDR_CTRL && paddr_in != ADDR_STRAP
            && paddr_in != ADDR_STAT |=> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    a_tach_tick: assert property (@(posedge clk_in) disable iff (rst_in)
        tach_tick_out |=> !tach_tick_out)
        else $error("tach tick longer than a cycle");
endmodule // fchk_top
`default_nettype wire

/* test/fchk_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serial bus host: idles both lines high through the pull-ups
module fchk_host_model (
    input  wire logic clk_in,    // system clock
    output logic      scl_out,   // clock line drive, 1 = released
    output logic      sda_out,   // data line drive, 1 = released
    output logic      start_out  // start seen, one-cycle pulse
);
    initial begin
        scl_out   = 1'b1;
        sda_out   = 1'b1;
        start_out = 1'b0;
    end
    // start, one clock low phase, then a stop: data rises while clock is high
    task automatic start_cond();
        @(posedge clk_in);
        sda_out   <= 1'b0;
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
        @(posedge clk_in);
        scl_out   <= 1'b0;
        repeat (2) @(posedge clk_in);
        scl_out   <= 1'b1;
        @(posedge clk_in);
        sda_out   <= 1'b1;
    endtask
    // a stalled host keeping the data line low
    task automatic hold_low(input int n);
        @(posedge clk_in);
        sda_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        sda_out <= 1'b1;
    endtask
endmodule // fchk_host_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fchk_pkg::*;
    logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, m_scl, m_sda, m_start;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, xtal = 0, xtal_ok = 0, drv_low = 0, err, xen, tb_clk, tick, oe_n, brst;
    logic [4:0] strap = 0;
    logic [6:0] dev_addr;
    logic [1:0] duty;
    logic fi, si, wi;
    fchk_sel_e ca = SEL_GND, cb = SEL_GND;
    wire sda = m_sda & oe_n;
    wire pa = ca == SEL_GND ? 1'b0 : ca == SEL_VCC ? 1'b1 : ca == SEL_SDA ? sda : m_scl;
    wire pb = cb == SEL_GND ? 1'b0 : cb == SEL_VCC ? 1'b1 : cb == SEL_SDA ? sda : m_scl;
    int err_total = 0, n_checks = 0, gap;
    always #50 clk_in = ~clk_in;
    always #10007 xtal = ~xtal;
    fchk_host_model u_fchk_host_model (.clk_in(clk_in), .scl_out(m_scl), .sda_out(m_sda),
        .start_out(m_start));
    fchk_top #(.TIMEOUT_CYCLES(20)) u_fchk_top (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pwm_freq_strap_in(strap[0]), .spin_strap_in(strap[1]),
        .bus_watchdog_strap_in(strap[2]), .duty_strap_bit0_in(strap[3]),
        .duty_strap_bit1_in(strap[4]), .addr_select_a_in(pa), .addr_select_b_in(pb),
        .scl_in(m_scl), .sda_in(sda), .bus_start_in(m_start), .crystal_in(xtal),
        .crystal_ok_in(xtal_ok), .crystal_en_out(xen), .timebase_clock_out(tb_clk),
        .tach_tick_out(tick), .sda_oe_n_out(oe_n), .bus_reset_out(brst),
        .dev_addr_out(dev_addr), .pwm_freq_init_out(fi), .spin_init_out(si),
        .watchdog_init_out(wi), .duty_init_out(duty), .sda_drive_low_in(drv_low));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        give_verdict();
    endtask
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        pen <= 1;
        n = 0;
        do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        err = pslverr;
        psel <= 0; pen <= 0;
    endtask
    task automatic do_reset(input logic [4:0] s);
        @(posedge clk_in);
        strap <= s; rst_in <= 1;
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        repeat (3) @(posedge clk_in);
    endtask
    // cycles between two rising edges of the clock output or of the tick
    task automatic rise_gap(input bit tk);
        int n, edges, cnt;
        logic s, p;
        n = 0; edges = 0; cnt = 0; p = 1;
        while (edges < 2 && n < 5000) begin
            @(posedge clk_in); #1;
            s = tk ? tick : tb_clk;
            cnt++;
            if (s && !p) begin
                if (edges == 1) gap = cnt;
                edges++;
                cnt = 0;
            end
            p = s; n++;
        end
        if (n >= 5000) hang();
    endtask
    task automatic straps_scn();
        logic [4:0] pat [2] = '{5'h16, 5'h09};
        foreach (pat[i]) begin
            do_reset(pat[i]);
            chk({duty, wi, si, fi}, pat[i]);
            apb(0, ADDR_STRAP, 0);
            chk(rd, {27'h0, pat[i]});
            strap <= ~pat[i];
            repeat (5) @(posedge clk_in);
            chk({duty, wi, si, fi}, pat[i]);
        end
    endtask
    task automatic clock_scn();
        chk(xen, 0);
        rise_gap(0); chk(gap, 2 * OSC_HALF_CYC);
        rise_gap(1); chk(gap, 8 * OSC_HALF_CYC);
        xtal_ok <= 1;
        apb(1, ADDR_CTRL, 32'h1); chk(err, 0);
        @(posedge clk_in);
        chk(xen, 1);
        apb(0, ADDR_STAT, 0); chk(rd[7], 1);
        repeat (10) @(posedge clk_in);
        rise_gap(0); chk(gap >= 199 && gap <= 202, 1);
        xtal_ok <= 0;
        repeat (10) @(posedge clk_in);
        rise_gap(0); chk(gap, 2 * OSC_HALF_CYC);
        apb(0, 8'h0C, 0);
        chk(err, 1);
        chk(rd, 0);
        apb(1, 8'h0C, 32'h0);
        chk(err, 1);
        @(posedge clk_in);
        chk(xen, 1);
        apb(1, ADDR_CTRL, 32'h0);
        @(posedge clk_in);
        chk(xen, 0);
    endtask
    task automatic addr_scn();
        for (int i = 0; i < 16; i++) begin
            ca <= fchk_sel_e'(i[1:0]);
            cb <= fchk_sel_e'(i[3:2]);
            u_fchk_host_model.start_cond();
            repeat (3) @(posedge clk_in);
            chk(dev_addr, {BASE_ADDR[6:4], i[3:0]});
        end
    endtask
    task automatic timeout_scn(input int hold, input bit expect_hit);
        int at;
        logic rel;
        at = -1; rel = 0;
        drv_low <= expect_hit;
        fork
            u_fchk_host_model.hold_low(hold);
            for (int n = 0; n < hold + 8; n++) begin
                @(posedge clk_in); #1;
                if (brst === 1'b1 && at < 0) begin at = n; rel = oe_n; end
            end
        join
        drv_low <= 0;
        chk(at >= 20 && at <= 23, expect_hit);
        if (expect_hit) chk(rel, 1);
    endtask
    initial begin
        repeat (100000) @(posedge clk_in);
        hang();
    end
    initial begin
        straps_scn();
        clock_scn();
        addr_scn();
        timeout_scn(15, 0);
        timeout_scn(30, 1);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
